// ==== fsmc_pkg.sv ====
// package for the flash security and margin command sequencer
// assumes a single 200 MHz clock domain and an Avalon-MM register slave
package fsmc_pkg;

    // register word addresses (byte address = 4 * index)
    localparam logic [3:0] REG_CMD0     = 4'h0;  // command code / first word
    localparam logic [3:0] REG_CMD1     = 4'h1;
    localparam logic [3:0] REG_CMD2     = 4'h2;
    localparam logic [3:0] REG_CMD3     = 4'h3;
    localparam logic [3:0] REG_CMD4     = 4'h4;
    localparam logic [3:0] REG_INDEX    = 4'h5;  // command_word_index
    localparam logic [3:0] REG_STATUS   = 4'h6;  // flash_status_reg
    localparam logic [3:0] REG_CONFIG   = 4'h7;  // mode, protection, backdoor_key_enable
    localparam logic [3:0] REG_KEY0     = 4'h8;  // stored comparison keys
    localparam logic [3:0] REG_MARGIN   = 4'hc;  // stored margins, security

    // status bit positions
    localparam int ST_COMMAND_COMPLETE_FLAG   = 7;
    localparam int ST_ACCESS_ERROR_FLAG = 5;
    localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
    localparam int ST_MG1    = 1;
    localparam int ST_MG0    = 0;

    // config bit positions
    localparam int CF_SPECIAL = 0;  // special (factory) mode
    localparam int CF_PROT    = 1;  // any area protected
    localparam int CF_BACKDOOR_KEY_ENABLE   = 2;  // two bits

    // command codes and launch indices
    localparam logic [7:0] CMD_UNSECURE = 8'h0b;
    localparam logic [7:0] CMD_BACKDOOR = 8'h0c;
    localparam logic [7:0] CMD_MARGIN   = 8'h0d;
    localparam logic [2:0] IDX_UNSECURE = 3'h0;
    localparam logic [2:0] IDX_BACKDOOR = 3'h4;
    localparam logic [2:0] IDX_MARGIN   = 3'h1;
    localparam logic [1:0] BACKDOOR_KEY_ENABLE_ON     = 2'h2;

    // margin settings and block codes
    localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
    localparam logic [15:0] MARGIN_ERASED = 16'h0001;
    localparam logic [15:0] MARGIN_PROG   = 16'h0002;
    localparam logic [1:0]  BLK_PFLASH    = 2'h0;
    localparam logic [1:0]  BLK_DFLASH    = 2'h1;

    // reset values
    localparam logic [15:0] RST_KEY       = 16'hffff;
    localparam logic [7:0]  RST_CONFIG    = 8'h00;

    // erase/verify duration in ns, converted to cycles
    localparam int CLK_NS       = 5;
    localparam int ERASE_NS     = 2000;
    localparam int ERASE_CYCLES = (ERASE_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic fail;
        logic fatal;
    } fsmc_verify_t;

    typedef struct packed {
        logic command_complete_flag;
        logic access_error_flag;
        logic protection_violation_flag;
        logic mg1;
        logic mg0;
    } fsmc_status_t;

endpackage

// ==== fsmc_eraser.sv ====
// erase-and-verify engine: timed busy period then verify result
// assumes start is a one-cycle pulse and array faults come from same clock
`timescale 1ns/1ps
module fsmc_eraser
    import fsmc_pkg::*;
#(
    parameter int CYCLES = ERASE_CYCLES
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         start,
    input  wire logic         fault_any,
    input  wire logic         fault_fatal,
    output logic              done,
    output fsmc_verify_t      result
);

    logic [15:0] count;
    logic        busy;

    // counts the erase time; faults are sampled at the end of the run
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count  <= 16'h0000;
            busy   <= 1'b0;
            done   <= 1'b0;
            result <= '0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy  <= 1'b1;
                count <= 16'(CYCLES - 1);
            end else if (busy) begin
                if (count == 16'h0000) begin
                    busy         <= 1'b0;
                    done         <= 1'b1;
                    result.fail  <= fault_any | fault_fatal;
                    result.fatal <= fault_fatal;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end

endmodule // fsmc_eraser

// ==== fsmc_seq.sv ====
// flash security and margin command sequencer with Avalon-MM slave
// assumes one clock; array fault inputs arrive on that clock
`timescale 1ns/1ps
module fsmc_seq
    import fsmc_pkg::*;
#(
    parameter int ERASE_LEN = ERASE_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        fault_any,
    input  wire logic        fault_fatal,
    output logic             secure,
    output logic [15:0]      pflash_margin,
    output logic [15:0]      dflash_margin,
    output logic             erase_active
);

    typedef enum logic [2:0] {
        S_IDLE, S_CHECK, S_ERASE, S_WAIT, S_DONE
    } fsmc_state_t;

    fsmc_state_t   state;
    fsmc_status_t  status;
    fsmc_verify_t  vres;
    logic [15:0]   cmd_word [5];
    logic [2:0]    command_word_index;
    logic [7:0]    config_bits;
    logic [15:0]   stored_key [4];
    logic [15:0]   margin_p;
    logic [15:0]   margin_d;
    logic          mismatch_latched;
    logic          resp_pending;
    logic          erase_start;
    logic          erase_done;
    logic [3:0]    widx;
    logic          wr_cmd;
    logic          launch;

    // word index from the byte address bits
    function automatic logic [3:0] word_of(input logic [5:0] a);
        return a[5:2];
    endfunction

    // true when a margin value is one of the three user levels
    function automatic logic margin_ok(input logic [15:0] v);
        return (v == MARGIN_NORMAL) || (v == MARGIN_ERASED) ||
               (v == MARGIN_PROG);
    endfunction

    assign widx   = word_of(address);
    // one-cycle answer: waitrequest high on the first cycle of a request
    assign waitrequest = (read | write) & ~resp_pending;
    assign wr_cmd = write & resp_pending;
    // writing a one to the complete bit clears it and launches
    assign launch = wr_cmd && (widx == REG_STATUS) &&
                    writedata[ST_COMMAND_COMPLETE_FLAG] && status.command_complete_flag;

    // request handshake: second cycle of every access completes
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            resp_pending <= 1'b0;
        end else begin
            resp_pending <= (read | write) & ~resp_pending;
        end
    end

    // read data register; unmapped words read zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h00000000;
        end else if (read & ~resp_pending) begin
            case (widx)
                REG_CMD0, REG_CMD1, REG_CMD2, REG_CMD3, REG_CMD4:
                    readdata <= {16'h0000, cmd_word[3'(widx)]};
                REG_INDEX:  readdata <= {29'h0, command_word_index};
                REG_STATUS: readdata <= {24'h0, status.command_complete_flag, 1'b0,
                                         status.access_error_flag, status.protection_violation_flag,
                                         2'b00, status.mg1, status.mg0};
                REG_CONFIG: readdata <= {24'h0, config_bits};
                REG_KEY0, 4'h9, 4'ha, 4'hb:
                    readdata <= {16'h0000, stored_key[2'(widx - REG_KEY0)]};
                REG_MARGIN: readdata <= {secure, mismatch_latched, 14'h0,
                                         margin_p[7:0], margin_d[7:0]};
                default:    readdata <= 32'h00000000;
            endcase
        end
    end

    // command parameter array, index, config and stored keys
    // writes during a running command are ignored; software must wait
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 5; i++) cmd_word[i] <= 16'h0000;
            for (int i = 0; i < 4; i++) stored_key[i] <= RST_KEY;
            command_word_index <= 3'h0;
            config_bits        <= RST_CONFIG;
        end else if (wr_cmd && status.command_complete_flag) begin
            case (widx)
                REG_CMD0, REG_CMD1, REG_CMD2, REG_CMD3, REG_CMD4:
                    cmd_word[3'(widx)] <= writedata[15:0];
                REG_INDEX:  command_word_index <= writedata[2:0];
                REG_CONFIG: config_bits <= writedata[7:0];
                REG_KEY0, 4'h9, 4'ha, 4'hb:
                    stored_key[2'(widx - REG_KEY0)] <= writedata[15:0];
                default: ;
            endcase
        end
    end

    fsmc_eraser #(
        .CYCLES (ERASE_LEN)
    ) u_eraser (
        .clock       (clock),
        .nrst        (nrst),
        .start       (erase_start),
        .fault_any   (fault_any),
        .fault_fatal (fault_fatal),
        .done        (erase_done),
        .result      (vres)
    );

    assign erase_active = (state == S_ERASE) || (state == S_WAIT);

    // command sequencer: checks, executes, reports
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state            <= S_IDLE;
            status           <= '{command_complete_flag: 1'b1, default: 1'b0};
            secure           <= 1'b1;
            margin_p         <= MARGIN_NORMAL;
            margin_d         <= MARGIN_NORMAL;
            mismatch_latched <= 1'b0;  // cleared only here
            erase_start      <= 1'b0;
        end else begin
            erase_start <= 1'b0;
            case (state)
                S_IDLE: begin
                    // error flags are write-one-to-clear while idle
                    if (wr_cmd && widx == REG_STATUS) begin
                        if (writedata[ST_ACCESS_ERROR_FLAG]) status.access_error_flag <= 1'b0;
                        if (writedata[ST_PROTECTION_VIOLATION_FLAG]) status.protection_violation_flag <= 1'b0;
                    end
                    if (launch) begin
                        status <= '0;  // complete clear while busy
                        state  <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    state <= S_DONE;
                    case (cmd_word[0][15:8])
                        CMD_UNSECURE: begin
                            if (command_word_index != IDX_UNSECURE ||
                                !config_bits[CF_SPECIAL])
                                status.access_error_flag <= 1'b1;
                            else if (config_bits[CF_PROT])
                                status.protection_violation_flag <= 1'b1;
                            else begin
                                erase_start <= 1'b1;
                                state       <= S_ERASE;
                            end
                        end
                        CMD_BACKDOOR: begin
                            // no verify or protection bits here
                            if (command_word_index != IDX_BACKDOOR ||
                                mismatch_latched)
                                status.access_error_flag <= 1'b1;
                            else if (config_bits[CF_BACKDOOR_KEY_ENABLE +: 2] != BACKDOOR_KEY_ENABLE_ON)
                                status.access_error_flag <= 1'b1;
                            else if (cmd_word[1] == stored_key[0] &&
                                     cmd_word[2] == stored_key[1] &&
                                     cmd_word[3] == stored_key[2] &&
                                     cmd_word[4] == stored_key[3])
                                secure <= 1'b0;  // all four match
                            else begin
                                status.access_error_flag    <= 1'b1;
                                mismatch_latched <= 1'b1;
                            end
                        end
                        CMD_MARGIN: begin
                            if (command_word_index != IDX_MARGIN ||
                                !config_bits[CF_SPECIAL] ||
                                !margin_ok(cmd_word[1]) ||
                                (cmd_word[0][1:0] != BLK_PFLASH &&
                                 cmd_word[0][1:0] != BLK_DFLASH))
                                status.access_error_flag <= 1'b1;
                            else if (cmd_word[0][1:0] == BLK_PFLASH) begin
                                // program level covers data reads as well
                                margin_p <= cmd_word[1];
                                margin_d <= cmd_word[1];
                            end else
                                margin_d <= cmd_word[1];  // data reads only
                        end
                        default: status.access_error_flag <= 1'b1;
                    endcase
                end
                S_ERASE: state <= S_WAIT;
                S_WAIT: begin
                    if (erase_done) begin
                        state <= S_DONE;
                        if (vres.fail)
                            status.mg1 <= 1'b1;  // keep secure
                        else
                            secure <= 1'b0;
                        if (vres.fatal)
                            status.mg0 <= 1'b1;
                    end
                end
                S_DONE: begin
                    status.command_complete_flag <= 1'b1;  // every outcome
                    state       <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // margin in force per array; a program-block command already copied
    // its level into the data margin, so a later data-block level wins
    assign pflash_margin = margin_p;
    assign dflash_margin = margin_d;

endmodule // fsmc_seq

// ==== fsmc_seq_checker.sv ====
// checker: bus timing, margin and security invariants of fsmc_seq
// assumes it is bound to fsmc_seq and sees that module's ports only
`timescale 1ns/1ps
module fsmc_seq_checker
    import fsmc_pkg::*;
#(
    parameter int ERASE_LEN = 4
) (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [5:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        secure,
    input wire logic [15:0] pflash_margin,
    input wire logic [15:0] dflash_margin,
    input wire logic        erase_active
);
    int         run;
    logic [5:0] hist;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!nrst);
    // erase length and recent launches; a counter avoids long repetitions
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            run  <= 0;
            hist <= 6'h00;
        end else begin
            run  <= erase_active ? run + 1 : 0;
            hist <= {hist[4:0], write && !waitrequest &&
                     address[5:2] == REG_STATUS && writedata[ST_COMMAND_COMPLETE_FLAG]};
        end
    end
    sequence req_wait;
        (read || write) && waitrequest ##1 !waitrequest;
    endsequence
    bus_answer_a: assert property ($rose(read || write) |-> req_wait)
        else $error("request not answered in its second cycle");
    read_hold_a: assert property ($changed(readdata) |->
        $past(read && waitrequest)) else $error("readdata changed idle");
    margin_legal_a: assert property (pflash_margin <= MARGIN_PROG &&
        dflash_margin <= MARGIN_PROG) else $error("illegal margin stored");
    data_follows_a: assert property ($changed(pflash_margin) |->
        dflash_margin == pflash_margin) else $error("data margin wrong");
    secure_no_rise_a: assert property (!$rose(secure))
        else $error("security set again without reset");
    erase_len_a: assert property ($fell(erase_active) |->
        run >= ERASE_LEN) else $error("erase ended too soon");
    erase_bound_a: assert property (run <= ERASE_LEN + 4)
        else $error("erase ran too long");
    margin_quiet_a: assert property (erase_active |=>
        $stable(pflash_margin) && $stable(dflash_margin))
        else $error("margin changed during erase");
    erase_launch_a: assert property ($rose(erase_active) |->
        hist != 6'h00) else $error("erase without launch");
    secure_cause_a: assert property ($fell(secure) |->
        hist != 6'h00 || $past(erase_active))
        else $error("security released without a command");
endmodule // fsmc_seq_checker

bind fsmc_seq fsmc_seq_checker #(.ERASE_LEN(ERASE_LEN)) fsmc_seq_checker_i (
    .clock(clock), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .secure(secure),
    .pflash_margin(pflash_margin), .dflash_margin(dflash_margin),
    .erase_active(erase_active));

// ==== fsmc_seq_bench.sv ====
// self-checking bench for fsmc_seq: command table, then reset and keys
// assumes the checker is bound to the design; one 200 MHz clock
`timescale 1ns/1ps
module fsmc_seq_bench
    import fsmc_pkg::*;
;
    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  code;
        logic [1:0]  blk;
        logic [15:0] val;
        logic [2:0]  idx;
        logic [1:0]  flt;
        logic [7:0]  st;
        logic [15:0] pm;
        logic [15:0] dm;
    } fsmc_row_t;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [5:0]  address = 6'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        fault_any = 1'b0;
    logic        fault_fatal = 1'b0;
    logic        secure;
    logic [15:0] pflash_margin;
    logic [15:0] dflash_margin;
    logic        erase_active;
    logic [31:0] q;
    logic        se;
    logic        sb;
    logic        ea;
    int          fail_count = 0;
    int          total_checks = 0;
    // ordinary cases; short erase keeps each unsecure row brief
    fsmc_row_t rows [16] = '{
        '{8'h01, 8'h0d, 2'h0, 16'h1, 3'h1, 2'h0, 8'h80, 16'h1, 16'h1},
        '{8'h01, 8'h0d, 2'h1, 16'h2, 3'h1, 2'h0, 8'h80, 16'h1, 16'h2},
        '{8'h01, 8'h0d, 2'h1, 16'h0, 3'h1, 2'h0, 8'h80, 16'h1, 16'h0},
        '{8'h01, 8'h0d, 2'h1, 16'h3, 3'h1, 2'h0, 8'ha0, 16'h1, 16'h0},
        '{8'h01, 8'h0d, 2'h2, 16'h0, 3'h1, 2'h0, 8'ha0, 16'h1, 16'h0},
        '{8'h01, 8'h0d, 2'h1, 16'h0, 3'h0, 2'h0, 8'ha0, 16'h1, 16'h0},
        '{8'h00, 8'h0d, 2'h1, 16'h0, 3'h1, 2'h0, 8'ha0, 16'h1, 16'h0},
        '{8'h01, 8'h0d, 2'h0, 16'h0, 3'h1, 2'h0, 8'h80, 16'h0, 16'h0},
        '{8'h01, 8'h0b, 2'h0, 16'h0, 3'h1, 2'h0, 8'ha0, 16'h0, 16'h0},
        '{8'h00, 8'h0b, 2'h0, 16'h0, 3'h0, 2'h0, 8'ha0, 16'h0, 16'h0},
        '{8'h03, 8'h0b, 2'h0, 16'h0, 3'h0, 2'h0, 8'h90, 16'h0, 16'h0},
        '{8'h01, 8'h0b, 2'h0, 16'h0, 3'h0, 2'h2, 8'h82, 16'h0, 16'h0},
        '{8'h01, 8'h0b, 2'h0, 16'h0, 3'h0, 2'h3, 8'h83, 16'h0, 16'h0},
        '{8'h02, 8'h0c, 2'h0, 16'hffff, 3'h4, 2'h0, 8'ha0, 16'h0, 16'h0},
        '{8'h08, 8'h0c, 2'h0, 16'hffff, 3'h3, 2'h0, 8'ha0, 16'h0, 16'h0},
        '{8'h01, 8'h0b, 2'h0, 16'h0, 3'h0, 2'h0, 8'h80, 16'h0, 16'h0}
    };
    // clock and design under test
    always #2.5 clock = ~clock;
    fsmc_seq #(.ERASE_LEN(4)) fsmc_seq_i (
        .clock(clock), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .fault_any(fault_any),
        .fault_fatal(fault_fatal), .secure(secure),
        .pflash_margin(pflash_margin), .dflash_margin(dflash_margin),
        .erase_active(erase_active));
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    // one Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic we, input logic [3:0] w,
                       input logic [31:0] d);
        int n;
        n = 0;
        write     <= we;
        read      <= !we;
        address   <= {w, 2'h0};
        writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'b0 && n < 40) begin
            @(posedge clock);
            n++;
        end
        if (n == 40) chk("waitrequest", 32'h0, 32'h1);
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] w, input logic [31:0] e,
                      input string s);
        bus(1'b0, w, 32'h0);
        chk(s, e, q);
    endtask
    task automatic rst();
        nrst <= 1'b0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
    endtask
    // load words, launch, poll only reads while busy
    // bench code runs outside the array, never from the key block
    task automatic launch(input fsmc_row_t r, input logic [15:0] k4);
        int n;
        n = 0;
        fault_any   <= r.flt[1];
        fault_fatal <= r.flt[0];
        bus(1'b1, REG_CONFIG, {24'h0, r.cfg});
        bus(1'b1, REG_CMD0, {16'h0, r.code, 6'h0, r.blk});
        for (int i = 1; i < 5; i++)
            bus(1'b1, 4'(i), {16'h0, (i == 4) ? k4 : r.val});
        bus(1'b1, REG_INDEX, {29'h0, r.idx});
        bus(1'b1, REG_STATUS, 32'h80);
        se = 1'b0;
        sb = 1'b0;
        do begin
            se |= erase_active;
            bus(1'b0, REG_STATUS, 32'h0);
            sb |= !q[ST_COMMAND_COMPLETE_FLAG];
            n++;
        end while (!q[ST_COMMAND_COMPLETE_FLAG] && n < 100);
        chk("status", {24'h0, r.st}, q);
    endtask
    task automatic summarize();
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog far beyond the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        summarize();
    end
    initial begin
        rst();
        foreach (rows[j]) begin
            launch(rows[j], rows[j].val);
            ea = rows[j].code == 8'h0b && rows[j].cfg[1:0] == 2'h1 &&
                 rows[j].idx == 3'h0;
            chk("erase", ea, se);
            chk("busy", 32'h1, sb);
            chk("pmargin", rows[j].pm, pflash_margin);
            chk("dmargin", rows[j].dm, dflash_margin);
            chk("secure", !(ea && rows[j].st == 8'h80), secure);
        end
        rst();
        chk("secure", 32'h1, secure);
        rd(REG_STATUS, 32'h80, "status");
        rd(REG_KEY0, 32'hffff, "key0");
        bus(1'b1, 4'hd, 32'h5a5a);
        rd(4'hd, 32'h0, "unmapped");
        launch('{8'h08, 8'h0c, 2'h0, 16'hffff, 3'h4, 2'h0, 8'ha0, 16'h0,
                 16'h0}, 16'h0000);
        rd(REG_MARGIN, 32'hc000_0000, "secreg");
        launch('{8'h08, 8'h0c, 2'h0, 16'hffff, 3'h4, 2'h0, 8'ha0, 16'h0,
                 16'h0}, 16'hffff);
        chk("secure", 32'h1, secure);
        rst();
        rd(REG_MARGIN, 32'h8000_0000, "secreg");
        launch('{8'h08, 8'h0c, 2'h0, 16'hffff, 3'h4, 2'h0, 8'h80, 16'h0,
                 16'h0}, 16'hffff);
        rd(REG_MARGIN, 32'h0, "secreg");
        summarize();
    end
endmodule // fsmc_seq_bench
